// *** dv/node_config_register_bank_asserts.sv ***
`default_nettype none
module node_config_register_bank_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Watched ports
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic cfg_wr_refused_o,
  input wire logic [15:0] dest_node_i,
  input wire logic route_local_o,
  input wire node_cfg_pkg::pll_ctl_t pll_ctl_o,
  input wire node_cfg_pkg::node_ctl_t node_ctl_o,
  input wire logic tile_reset_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic [31:0] wd_q;
  logic ok;
  assign ok = cfg_wr_i && !cfg_wr_refused_o;
  always_ff @(posedge clk_i)
  begin
    wd_q <= cfg_wdata_i;
  end
  chk_tile_reset_cause:
  assert property (ok && cfg_addr_i == 8'h06 && !cfg_wdata_i[31] |=> tile_reset_o)
    else $error("tile reset missing after pll write");
  chk_tile_reset_only:
  assert property (tile_reset_o |-> $past(ok && cfg_addr_i == 8'h06 && !cfg_wdata_i[31]))
    else $error("tile reset without cause");
  chk_pll_fields:
  assert property (ok && cfg_addr_i == 8'h06 |=> pll_ctl_o == {wd_q[25:23], wd_q[20:8], wd_q[6:0], 1'b0, wd_q[30:28]})
    else $error("pll fields wrong");
  chk_pll_locked:
  assert property (cfg_wr_i && cfg_wr_refused_o |=> $stable(pll_ctl_o) && !tile_reset_o)
    else $error("refused write had an effect");
  chk_node_id_write:
  assert property (ok && cfg_addr_i == 8'h05 |=> node_ctl_o.node_id == wd_q[15:0])
    else $error("node id not written");
  chk_switch_div:
  assert property (ok && cfg_addr_i == 8'h07 |=> node_ctl_o.switch_div == wd_q[15:0])
    else $error("switch divider not written");
  chk_header_mode:
  assert property (ok && cfg_addr_i == 8'h04 |=> node_ctl_o.header_one_byte == wd_q[0])
    else $error("header mode not written");
  chk_route_local:
  assert property (arst_n_i |=> route_local_o == $past(dest_node_i == node_ctl_o.node_id))
    else $error("local flag wrong");
  chk_ref_div_write:
  assert property (ok && cfg_addr_i == 8'h08 |=> node_ctl_o.ref_div == wd_q[15:0])
    else $error("reference divider not written");
endmodule
bind node_config_register_bank node_config_register_bank_asserts u_asserts (.clk_i, .arst_n_i, .cfg_wr_i,
  .cfg_addr_i, .cfg_wdata_i, .cfg_wr_refused_o, .dest_node_i, .route_local_o, .pll_ctl_o, .node_ctl_o, .tile_reset_o);
`default_nettype wire

// *** dv/node_config_register_bank_tb.sv ***
`default_nettype none
module node_config_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, refused, tile_rst, local_q;
  logic [7:0] boot = 8'h5a, addr = 8'h00;
  logic [13:0] otp = 14'h2b3c;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] dest = 16'h0;
  logic [3:0] dir;
  logic [31:0] m [0:255];
  int err_count = 0, num_checks = 0, seed = 72;
  always #20 clk_i = ~clk_i;
  node_config_register_bank #(.SWITCH_REVISION(8'h12), .DEVICE_PROCESSORS(8'h04), .JTAG_DEVICE_ID(32'h13572468),
    .METAL_ID(18'h2a5a5)) u_dut (.clk_i, .arst_n_i,
    .boot_control_pins_i(boot), .otp_user_code_i(otp), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr),
    .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_wr_refused_o(refused), .dest_node_i(dest),
    .route_dir_o(dir), .route_local_o(local_q), .pll_ctl_o(), .node_ctl_o(), .tile_reset_o(tile_rst));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h04: return 32'h80000101;
      8'h05, 8'h07, 8'h08: return 32'h0000ffff;
      8'h06: return 32'hf39fff7f;
      8'h0c, 8'h0d: return 32'hffffffff;
      8'h10: return 32'h00000003;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] rdv(input logic [7:0] a);
    case (a)
      8'h00: return {8'h00, boot, 16'h1201};
      8'h01: return 32'h00080204;
      8'h09: return 32'h13572468;
      8'h0a: return {otp, 18'h2a5a5};
      default: return m[a];
    endcase
  endfunction
  task automatic mreset();
    foreach (m[i]) m[i] = 32'h0;
    m[8] = 32'h3;
  endtask
  // One write or read, then routing compared
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [15:0] ds);
    logic lk;
    logic [31:0] x, y;
    logic [15:0] v;
    int k;
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    dest <= ds;
    x = rdv(a);
    lk = m[4][31] || (a == 8'h06 && m[4][8]);
    v = ds ^ m[5][15:0];
    k = 15;
    while (k > 0 && !v[k]) k--;
    y = k < 8 ? m[12] >> (4 * k) : m[13] >> (4 * k - 32);
    @(negedge clk_i);
    chk("refused", {31'h0, w && lk}, {31'h0, refused});
    if (w && !lk) m[a] = d & msk(a);
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk_i);
    if (!w) chk("rdata", x, rdata);
    chk("tile_reset", {31'h0, w && !lk && a == 8'h06 && !d[31]}, {31'h0, tile_rst});
    chk("route_dir", {28'h0, y[3:0]}, {28'h0, dir});
    chk("route_local", {31'h0, v == 16'h0}, {31'h0, local_q});
  endtask
  task automatic rnd(input logic lock);
    logic [31:0] r, d;
    r = $random(seed);
    d = $random(seed);
    if (r[4:0] == 5'h04 && !lock) d[31] = 1'b0;
    op(r[5], {3'h0, r[4:0]}, d, m[5][15:0] ^ (d[15:0] & 16'((17'h1 << r[10:6]) - 17'h1)));
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    mreset();
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      for (int a = 0; a < 18; a++) op(1'b0, 8'(a), 32'h0, 16'h0);
      repeat (300) rnd(1'b0);
      op(1'b1, 8'h04, 32'h80000101, 16'h0);
      repeat (40) rnd(1'b1);
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      boot <= boot + 8'h11;
      mreset();
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
    end
    final_report();
  end
  initial
  begin
    #200000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire

// *** verilog/node_cfg_pkg.sv ***
`default_nettype none
package node_cfg_pkg;
  // Register numbers
  localparam logic [7:0] IDX_IDENTITY = 8'h00;
  localparam logic [7:0] IDX_DESCRIPTION = 8'h01;
  localparam logic [7:0] IDX_SWITCH_CFG = 8'h04;
  localparam logic [7:0] IDX_NODE_ID = 8'h05;
  localparam logic [7:0] IDX_PLL = 8'h06;
  localparam logic [7:0] IDX_SWITCH_DIV = 8'h07;
  localparam logic [7:0] IDX_REF_DIV = 8'h08;
  localparam logic [7:0] IDX_JTAG_ID = 8'h09;
  localparam logic [7:0] IDX_USER_CODE = 8'h0a;
  localparam logic [7:0] IDX_DIR_LOW = 8'h0c;
  localparam logic [7:0] IDX_DIR_HIGH = 8'h0d;
  localparam logic [7:0] IDX_RESERVED = 8'h10;
  // Switch configuration fields
  localparam int CFG_LOCK_ALL_BIT = 31;
  localparam int CFG_LOCK_PLL_BIT = 8;
  localparam int CFG_HEADER_BIT = 0;
  // PLL setting fields
  localparam int PLL_NO_RESET_BIT = 31;
  localparam int PLL_NO_WAIT_BIT = 30;
  localparam int PLL_BYPASS_BIT = 29;
  localparam int PLL_JTAG_BOOT_BIT = 28;
  localparam logic [31:0] PLL_WRITABLE_MASK = 32'hf39fff7f;
  // Reset values
  localparam logic [31:0] PLL_RESET_VALUE = 32'h00000000;
  localparam logic [15:0] SWITCH_DIV_RESET = 16'h0000;
  localparam logic [15:0] REF_DIV_RESET = 16'h0003;
  localparam logic [15:0] NODE_ID_RESET = 16'h0000;
  localparam logic [31:0] DIR_RESET = 32'h00000000;
  localparam logic [1:0] RESERVED_RESET = 2'h0;

  typedef struct packed {
    logic [23:0] pll_value;
    logic pll_no_wait;
    logic pll_bypass;
    logic jtag_boot;
  } pll_ctl_t;

  typedef struct packed {
    logic header_one_byte;
    logic [15:0] node_id;
    logic [15:0] switch_div;
    logic [15:0] ref_div;
  } node_ctl_t;
endpackage
`default_nettype wire

// *** verilog/node_config_register_bank.sv ***
// Overview of operation
// - Identity register shows boot pins caught after reset release, revision and version.
// - Description register shows link count, local and device processor counts.
// - Configuration bit 31 set refuses writes to all switch control registers.
// - Configuration bit 8 set refuses writes to the PLL setting register.
// - Configuration bit 0 picks one-byte headers when set, two-byte when clear.
// - Node identifier is sixteen writable bits, reset zero, upper bits zero.
// - An accepted PLL setting write pulses tile reset unless no-reset is set.
// - PLL setting bit 31 set applies the setting without chip reset.
// - PLL setting bit 30 set skips waiting for PLL relock.
// - Bit 29 bypasses the PLL; bit 28 forces boot from JTAG.
// - PLL fields hold output divider, feedback multiplier, input divider minus one.
// - Switch clock divider is sixteen writable bits resetting to zero.
// - Reference clock divider is sixteen writable bits resetting to three.
// - User code register shows OTP user code and metal-fixable code.
// - Top mismatching node bit selects dimension; low dimensions use low register.
// - Low directions register holds eight four-bit fields, reset zero.
// - High dimensions take direction from high register fields, reset zero.
`default_nettype none
module node_config_register_bank #(
  parameter logic [7:0] SWITCH_REVISION = 8'h01,
  parameter logic [7:0] SWITCH_VERSION = 8'h01,
  parameter logic [7:0] LINK_COUNT = 8'h08,
  parameter logic [7:0] LOCAL_PROCESSORS = 8'h02,
  parameter logic [7:0] DEVICE_PROCESSORS = 8'h02,
  // Arbitrary value
  parameter logic [31:0] JTAG_DEVICE_ID = 32'h00000001,
  // Arbitrary value
  parameter logic [17:0] METAL_ID = 18'h00001
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Straps and one-time-programmed values
  input wire logic [7:0] boot_control_pins_i,
  input wire logic [13:0] otp_user_code_i,
  // Configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_wr_refused_o,
  // Routing lookup
  input wire logic [15:0] dest_node_i,
  output logic [3:0] route_dir_o,
  output logic route_local_o,
  // Control outputs
  output node_cfg_pkg::pll_ctl_t pll_ctl_o,
  output node_cfg_pkg::node_ctl_t node_ctl_o,
  output logic tile_reset_o
);
  logic boot_caught_reg;
  logic [7:0] boot_pins_reg;
  logic lock_all_reg;
  logic lock_pll_reg;
  logic header_reg;
  logic [15:0] node_id_reg;
  logic [31:0] pll_reg;
  logic [15:0] switch_div_reg;
  logic [15:0] ref_div_reg;
  logic [31:0] dir_low_reg;
  logic [31:0] dir_high_reg;
  logic [1:0] reserved_reg;
  logic wr_cfg;
  logic wr_ok;
  logic pll_wr;
  logic pll_hit;
  logic wr_node_id;
  logic wr_switch_div;
  logic wr_ref_div;
  logic wr_dir_low;
  logic wr_dir_high;
  logic wr_reserved;
  logic [15:0] diff;
  logic [3:0] dim;
  logic [31:0] rdata_next;

  function automatic logic [3:0] top_bit(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (v[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  assign wr_cfg = cfg_wr_i && (cfg_addr_i == node_cfg_pkg::IDX_SWITCH_CFG);
  assign wr_ok = cfg_wr_i && !lock_all_reg;
  assign pll_hit = (cfg_addr_i == node_cfg_pkg::IDX_PLL);
  assign pll_wr = wr_ok && !lock_pll_reg && pll_hit;
  assign cfg_wr_refused_o = cfg_wr_i && (lock_all_reg || (lock_pll_reg && pll_hit));
  // Per-register strobes, each gated by the whole lock
  assign wr_node_id = wr_ok && (cfg_addr_i == node_cfg_pkg::IDX_NODE_ID);
  assign wr_switch_div = wr_ok && (cfg_addr_i == node_cfg_pkg::IDX_SWITCH_DIV);
  assign wr_ref_div = wr_ok && (cfg_addr_i == node_cfg_pkg::IDX_REF_DIV);
  assign wr_dir_low = wr_ok && (cfg_addr_i == node_cfg_pkg::IDX_DIR_LOW);
  assign wr_dir_high = wr_ok && (cfg_addr_i == node_cfg_pkg::IDX_DIR_HIGH);
  assign wr_reserved = wr_ok && (cfg_addr_i == node_cfg_pkg::IDX_RESERVED);

  // boot pins caught after reset release
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      boot_caught_reg <= 1'b0;
      boot_pins_reg <= 8'h00;
    end
    else if (!boot_caught_reg)
    begin
      boot_caught_reg <= 1'b1;
      boot_pins_reg <= boot_control_pins_i;
    end
  end

  // Switch configuration lock bits
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lock_all_reg <= 1'b0;
      lock_pll_reg <= 1'b0;
    end
    else if (wr_cfg && !lock_all_reg)
    begin
      lock_all_reg <= cfg_wdata_i[node_cfg_pkg::CFG_LOCK_ALL_BIT];
      lock_pll_reg <= cfg_wdata_i[node_cfg_pkg::CFG_LOCK_PLL_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      header_reg <= 1'b0;
    end
    else if (wr_cfg && !lock_all_reg)
    begin
      header_reg <= cfg_wdata_i[node_cfg_pkg::CFG_HEADER_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      node_id_reg <= node_cfg_pkg::NODE_ID_RESET;
    end
    else if (wr_node_id)
    begin
      node_id_reg <= cfg_wdata_i[15:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pll_reg <= node_cfg_pkg::PLL_RESET_VALUE;
    end
    else if (pll_wr)
    begin
      pll_reg <= cfg_wdata_i & node_cfg_pkg::PLL_WRITABLE_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tile_reset_o <= 1'b0;
    end
    else
    begin
      tile_reset_o <= pll_wr && !cfg_wdata_i[node_cfg_pkg::PLL_NO_RESET_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      switch_div_reg <= node_cfg_pkg::SWITCH_DIV_RESET;
    end
    else if (wr_switch_div)
    begin
      switch_div_reg <= cfg_wdata_i[15:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ref_div_reg <= node_cfg_pkg::REF_DIV_RESET;
    end
    else if (wr_ref_div)
    begin
      ref_div_reg <= cfg_wdata_i[15:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dir_low_reg <= node_cfg_pkg::DIR_RESET;
    end
    else if (wr_dir_low)
    begin
      dir_low_reg <= cfg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dir_high_reg <= node_cfg_pkg::DIR_RESET;
    end
    else if (wr_dir_high)
    begin
      dir_high_reg <= cfg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reserved_reg <= node_cfg_pkg::RESERVED_RESET;
    end
    else if (wr_reserved)
    begin
      reserved_reg <= cfg_wdata_i[1:0];
    end
  end

  assign diff = dest_node_i ^ node_id_reg;
  assign dim = top_bit(diff);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      route_local_o <= 1'b1;
    end
    else
    begin
      route_local_o <= (diff == 16'h0000);
    end
  end

  // direction lookup, local packets take dimension 0
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      route_dir_o <= 4'h0;
    end
    else
    begin
      if (dim[3])
      begin
        route_dir_o <= dir_high_reg[{dim[2:0], 2'b00} +: 4];
      end
      else
      begin
        route_dir_o <= dir_low_reg[{dim[2:0], 2'b00} +: 4];
      end
    end
  end

  always_comb
  begin
    rdata_next = 32'h00000000;
    case (cfg_addr_i)
      node_cfg_pkg::IDX_IDENTITY: rdata_next = {8'h00, boot_pins_reg, SWITCH_REVISION, SWITCH_VERSION};
      node_cfg_pkg::IDX_DESCRIPTION: rdata_next = {8'h00, LINK_COUNT, LOCAL_PROCESSORS, DEVICE_PROCESSORS};
      node_cfg_pkg::IDX_SWITCH_CFG: rdata_next = {lock_all_reg, 22'h000000, lock_pll_reg, 7'h00, header_reg};
      node_cfg_pkg::IDX_NODE_ID: rdata_next = {16'h0000, node_id_reg};
      node_cfg_pkg::IDX_PLL: rdata_next = pll_reg;
      node_cfg_pkg::IDX_SWITCH_DIV: rdata_next = {16'h0000, switch_div_reg};
      node_cfg_pkg::IDX_REF_DIV: rdata_next = {16'h0000, ref_div_reg};
      node_cfg_pkg::IDX_JTAG_ID: rdata_next = JTAG_DEVICE_ID;
      node_cfg_pkg::IDX_USER_CODE: rdata_next = {otp_user_code_i, METAL_ID};
      node_cfg_pkg::IDX_DIR_LOW: rdata_next = dir_low_reg;
      node_cfg_pkg::IDX_DIR_HIGH: rdata_next = dir_high_reg;
      node_cfg_pkg::IDX_RESERVED: rdata_next = {30'h00000000, reserved_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_rdata_o <= 32'h00000000;
    end
    else if (cfg_rd_i)
    begin
      cfg_rdata_o <= rdata_next;
    end
  end

  always_comb
  begin
    pll_ctl_o.pll_value = {pll_reg[25:23], pll_reg[20:8], pll_reg[6:0], 1'b0};
    pll_ctl_o.pll_no_wait = pll_reg[node_cfg_pkg::PLL_NO_WAIT_BIT];
    pll_ctl_o.pll_bypass = pll_reg[node_cfg_pkg::PLL_BYPASS_BIT];
    pll_ctl_o.jtag_boot = pll_reg[node_cfg_pkg::PLL_JTAG_BOOT_BIT];
    node_ctl_o.header_one_byte = header_reg;
    node_ctl_o.node_id = node_id_reg;
    node_ctl_o.switch_div = switch_div_reg;
    node_ctl_o.ref_div = ref_div_reg;
  end
endmodule
`default_nettype wire
